// >>> hdl/ssrpd_pkg.sv
// Constants and types for the DRAM self-refresh and power-down controller
package ssrpd_pkg;

   localparam int CLK_PERIOD_NS = 50;

   // Clock-enable pulse window; internal refresh must start inside it
   localparam int T_CKE_NS    = 150;
   localparam int CKE_CYC_RAW = T_CKE_NS / CLK_PERIOD_NS;
   localparam int CKE_CYC     = (CKE_CYC_RAW < 1) ? 1 : CKE_CYC_RAW;

   // Entry blanking: receivers stay on this long after clock enable falls
   localparam int T_CPDED_NS    = 50;
   localparam int CPDED_CYC_RAW = (T_CPDED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CPDED_CYC     = (CPDED_CYC_RAW < 1) ? 1 : CPDED_CYC_RAW;

   // Self-refresh internal refresh interval
   localparam int T_SR_REF_NS    = 7800;
   localparam int SR_REF_CYC_RAW = T_SR_REF_NS / CLK_PERIOD_NS;
   localparam int SR_REF_CYC     = (SR_REF_CYC_RAW < 1) ? 1 : SR_REF_CYC_RAW;

   localparam logic [7:0] ADDR_MR0  = 8'h00;
   localparam logic [7:0] ADDR_MR1  = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;

   localparam int MR0_PPD_FAST_BIT = 12;
   localparam int MR1_DLL_DIS_BIT  = 0;

   localparam logic [15:0] MR0_RST = 16'h0000;
   localparam logic [15:0] MR1_RST = 16'h0000;

   typedef enum logic [2:0] {
      ST_NORM = 3'b000,
      ST_PEND = 3'b001,
      ST_APD  = 3'b010,
      ST_PPD  = 3'b011,
      ST_SREF = 3'b100,
      ST_RST  = 3'b101
   } ssrpd_state_t;

   typedef struct packed {
      logic cke;
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
   } ssrpd_pins_t;

   localparam ssrpd_pins_t PINS_RST = 5'h0f;

endpackage

// >>> hdl/ssrpd_ctrl.sv
// Self-refresh and power-down state controller of the DRAM
// Contract
// - Decode self-refresh entry from pins
// - DLL off in self-refresh, reset on exit
// - Self-refresh ignores inputs, gates clock
// - Internal refresh within clock-enable pulse
// - Enter power-down on clock enable low
// - Finish running operation before low power; self-refresh entry does not wait for op_busy_i
// - Precharge or active power-down by banks
// - Buffers off, receivers after blanking
// - Precharge power-down DLL follows mode bit
// - Reset pin low leaves power-down
// - Exit on clock enable high
`timescale 1ns/1ps
`default_nettype none

module ssrpd_ctrl (
   input  wire logic                   core_clk_i,    // 20 MHz clock
   input  wire logic                   rst_b_i,       // Async reset, low
   input  wire logic                   ce_i,          // Clock enable, freezes state
   input  wire logic                   cke_i,         // Clock enable pin
   input  wire logic                   cs_b_i,        // Chip select pin, low
   input  wire logic                   ras_b_i,       // Row strobe pin, low
   input  wire logic                   cas_b_i,       // Column strobe pin, low
   input  wire logic                   we_b_i,        // Write enable pin, low
   input  wire logic                   dram_rst_b_i,  // Device reset pin, low
   input  wire logic                   banks_open_i,  // Any bank open
   input  wire logic                   op_busy_i,     // Activate/precharge/refresh running
   input  wire logic [7:0]             addr_i,        // Register byte address
   input  wire logic [31:0]            wdata_i,       // Register write data
   input  wire logic                   wr_i,          // Write strobe
   input  wire logic                   rd_i,          // Read strobe
   output logic      [31:0]            rdata_o,       // Read data, cycle after strobe
   output ssrpd_pkg::ssrpd_state_t     lp_state_o,    // Low-power state
   output logic                        dll_en_o,      // DLL running
   output logic                        dll_rst_o,     // DLL reset pulse
   output logic                        int_clk_en_o,  // Internal clock enable
   output logic                        io_buf_en_o,   // Data buffers enabled
   output logic                        cmd_rcv_en_o,  // Command receivers enabled
   output logic                        sref_ref_o     // Internal refresh pulse
);

   ssrpd_pkg::ssrpd_pins_t pins_meta_r;
   ssrpd_pkg::ssrpd_pins_t pins_r;
   logic                   drst_meta_r;
   logic                   drst_r;
   logic                   cke_q_r;
   ssrpd_pkg::ssrpd_state_t st_r;
   ssrpd_pkg::ssrpd_state_t st_nxt;
   logic [15:0]            mr0_r;
   logic [15:0]            mr1_r;
   logic [7:0]             blk_r;
   logic [7:0]             blk_nxt;
   logic [7:0]             ref_cnt_r;
   logic [7:0]             ref_cnt_nxt;

   // Pins come from another timing domain; two flops before any decode
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pins_meta_r <= ssrpd_pkg::PINS_RST;
         pins_r      <= ssrpd_pkg::PINS_RST;
         drst_meta_r <= 1'b0;
         drst_r      <= 1'b0;
         cke_q_r     <= 1'b0;
      end else if (ce_i) begin
         pins_meta_r <= '{cke_i, cs_b_i, ras_b_i, cas_b_i, we_b_i};
         pins_r      <= pins_meta_r;
         drst_meta_r <= dram_rst_b_i;
         drst_r      <= drst_meta_r;
         cke_q_r     <= pins_r.cke;
      end
   end

   wire nop_des  = pins_r.cs_b | (pins_r.ras_b & pins_r.cas_b & pins_r.we_b);
   wire cke_fall = cke_q_r & ~pins_r.cke;
   wire cke_rise = ~cke_q_r & pins_r.cke;
   wire sre_hit  = cke_fall & ~pins_r.cs_b & ~pins_r.ras_b & ~pins_r.cas_b
                   & pins_r.we_b;
   wire pd_hit   = cke_fall & nop_des;
   wire exit_hit = cke_rise & nop_des;
   wire dll_on   = ~mr1_r[ssrpd_pkg::MR1_DLL_DIS_BIT];
   wire ppd_fast = mr0_r[ssrpd_pkg::MR0_PPD_FAST_BIT];
   wire lp_nxt   = (st_nxt == ssrpd_pkg::ST_PEND) || (st_nxt == ssrpd_pkg::ST_APD)
                   || (st_nxt == ssrpd_pkg::ST_PPD);

   always_comb begin
      st_nxt = st_r;
      if (!drst_r) begin
         st_nxt = ssrpd_pkg::ST_RST;
      end else begin
         unique case (st_r)
            ssrpd_pkg::ST_NORM: begin
               if (sre_hit) begin
                  st_nxt = ssrpd_pkg::ST_SREF;
               end else if (pd_hit) begin
                  st_nxt = ssrpd_pkg::ST_PEND;
               end
            end
            ssrpd_pkg::ST_PEND: begin
               if (exit_hit) begin
                  st_nxt = ssrpd_pkg::ST_NORM;
               end else if (!op_busy_i) begin
                  // Running operation completes first
                  st_nxt = banks_open_i ? ssrpd_pkg::ST_APD : ssrpd_pkg::ST_PPD;
               end
            end
            ssrpd_pkg::ST_APD, ssrpd_pkg::ST_PPD: begin
               if (exit_hit) begin
                  st_nxt = ssrpd_pkg::ST_NORM;
               end
            end
            ssrpd_pkg::ST_SREF: begin
               // Only clock enable and reset are looked at here
               if (cke_rise) begin
                  st_nxt = ssrpd_pkg::ST_NORM;
               end
            end
            ssrpd_pkg::ST_RST: begin
               st_nxt = ssrpd_pkg::ST_NORM;
            end
            default: begin
               st_nxt = ssrpd_pkg::ST_RST;
            end
         endcase
      end
   end

   // Blanking count after entry keeps receivers alive for trailing no-ops
   assign blk_nxt = (st_r == ssrpd_pkg::ST_NORM && st_nxt == ssrpd_pkg::ST_PEND)
                    ? 8'(ssrpd_pkg::CPDED_CYC)
                    : ((blk_r != 8'h00 && lp_nxt) ? blk_r - 8'h01 : 8'h00);

   // First refresh lands inside the clock-enable window, then periodic
   wire ref_due = (st_r == ssrpd_pkg::ST_SREF) && (st_nxt == ssrpd_pkg::ST_SREF)
                  && (ref_cnt_r == 8'h00);
   assign ref_cnt_nxt = (st_r != ssrpd_pkg::ST_SREF) ? 8'(ssrpd_pkg::CKE_CYC - 1)
                        : (ref_due ? 8'(ssrpd_pkg::SR_REF_CYC - 1)
                                   : ref_cnt_r - 8'h01);

   wire dll_nxt = dll_on && (st_nxt != ssrpd_pkg::ST_SREF)
                  && !(st_nxt == ssrpd_pkg::ST_PPD && !ppd_fast);
   wire dll_rst_nxt = dll_on && (st_r == ssrpd_pkg::ST_SREF)
                      && (st_nxt == ssrpd_pkg::ST_NORM);
   wire rcv_nxt = (st_nxt == ssrpd_pkg::ST_NORM) || (lp_nxt && blk_nxt != 8'h00);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r      <= ssrpd_pkg::ST_RST;
         blk_r     <= 8'h00;
         ref_cnt_r <= 8'h00;
      end else if (ce_i) begin
         st_r      <= st_nxt;
         blk_r     <= blk_nxt;
         ref_cnt_r <= ref_cnt_nxt;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lp_state_o   <= ssrpd_pkg::ST_RST;
         dll_en_o     <= 1'b0;
         dll_rst_o    <= 1'b0;
         int_clk_en_o <= 1'b0;
         io_buf_en_o  <= 1'b0;
         cmd_rcv_en_o <= 1'b0;
         sref_ref_o   <= 1'b0;
      end else if (ce_i) begin
         lp_state_o   <= st_nxt;
         dll_en_o     <= dll_nxt;
         dll_rst_o    <= dll_rst_nxt;
         int_clk_en_o <= (st_nxt != ssrpd_pkg::ST_SREF);
         io_buf_en_o  <= (st_nxt == ssrpd_pkg::ST_NORM);
         cmd_rcv_en_o <= rcv_nxt;
         sref_ref_o   <= ref_due;
      end
   end

   // Register port; unmapped addresses read zero
   wire [31:0] stat_word = {25'h0, cmd_rcv_en_o, io_buf_en_o, int_clk_en_o,
                            dll_en_o, st_r};
   wire [31:0] rd_sel = (addr_i == ssrpd_pkg::ADDR_MR0)  ? {16'h0, mr0_r}
                      : (addr_i == ssrpd_pkg::ADDR_MR1)  ? {16'h0, mr1_r}
                      : (addr_i == ssrpd_pkg::ADDR_STAT) ? stat_word
                      : 32'h0;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mr0_r   <= ssrpd_pkg::MR0_RST;
         mr1_r   <= ssrpd_pkg::MR1_RST;
         rdata_o <= 32'h0;
      end else if (ce_i) begin
         if (wr_i && addr_i == ssrpd_pkg::ADDR_MR0) begin
            mr0_r <= wdata_i[15:0];
         end
         if (wr_i && addr_i == ssrpd_pkg::ADDR_MR1) begin
            mr1_r <= wdata_i[15:0];
         end
         rdata_o <= rd_i ? rd_sel : 32'h0;
      end
   end

   localparam int CKE_CYC_A = ssrpd_pkg::CKE_CYC;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_sref_exit;
      st_r == ssrpd_pkg::ST_SREF ##1 st_r == ssrpd_pkg::ST_NORM;
   endsequence

   sequence s_pd_enter;
      st_r == ssrpd_pkg::ST_NORM ##1 st_r == ssrpd_pkg::ST_PEND;
   endsequence

   a_sre_decode_go:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_NORM && sre_hit
                    |=> st_r == ssrpd_pkg::ST_SREF)
      else $error("self-refresh entry not taken");

   a_pd_entry_go:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_NORM && pd_hit
                    |=> st_r == ssrpd_pkg::ST_PEND)
      else $error("power-down entry not taken");

   a_sref_dll_off:
   assert property (st_r == ssrpd_pkg::ST_SREF |-> !dll_en_o)
      else $error("DLL running in self-refresh");

   a_sref_dll_reset:
   assert property (s_sref_exit ##0 dll_on |-> dll_rst_o && dll_en_o)
      else $error("DLL not reset on self-refresh exit");

   a_sref_clk_gate:
   assert property (st_r == ssrpd_pkg::ST_SREF |-> !int_clk_en_o && !cmd_rcv_en_o)
      else $error("clock or receivers on in self-refresh");

   a_sref_first_ref:
   assert property ($rose(st_r == ssrpd_pkg::ST_SREF) |-> ##[1:CKE_CYC_A]
                    (sref_ref_o || !ce_i || st_r != ssrpd_pkg::ST_SREF))
      else $error("no internal refresh within window");

   a_pend_busy_hold:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_PEND && op_busy_i && !exit_hit
                    |=> st_r == ssrpd_pkg::ST_PEND)
      else $error("low power before operation done");

   a_pd_kind_sel:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_PEND && !op_busy_i && !exit_hit
                    |=> st_r == ($past(banks_open_i) ? ssrpd_pkg::ST_APD : ssrpd_pkg::ST_PPD))
      else $error("wrong power-down kind");

   a_ppd_dll_mode:
   assert property (st_r == ssrpd_pkg::ST_PPD && dll_on && $stable(mr0_r)
                    |-> dll_en_o == ppd_fast)
      else $error("precharge power-down DLL mode wrong");

   a_rst_pin_exit:
   assert property (ce_i && !drst_r |=> st_r == ssrpd_pkg::ST_RST)
      else $error("reset pin did not force reset state");

   a_pd_exit_go:
   assert property (ce_i && drst_r && exit_hit && (st_r == ssrpd_pkg::ST_APD
                    || st_r == ssrpd_pkg::ST_PPD) |=> st_r == ssrpd_pkg::ST_NORM
                    && io_buf_en_o)
      else $error("power-down exit not taken");

   a_blank_rcv_on:
   assert property (s_pd_enter |-> cmd_rcv_en_o && !io_buf_en_o)
      else $error("receivers off during blanking");

   // Blanking over means the command receivers are dark
   a_blank_rcv_off:
   assert property (st_r inside {ssrpd_pkg::ST_PEND, ssrpd_pkg::ST_APD, ssrpd_pkg::ST_PPD}
                    && blk_r == 8'h00 |-> !cmd_rcv_en_o)
      else $error("receivers on after blanking");

   a_pd_buf_off:
   assert property (st_r inside {ssrpd_pkg::ST_PEND, ssrpd_pkg::ST_APD, ssrpd_pkg::ST_PPD}
                    |-> !io_buf_en_o)
      else $error("data buffers on in power-down");

   a_apd_dll_on:
   assert property (st_r == ssrpd_pkg::ST_APD && dll_on && $stable(mr1_r)
                    |-> dll_en_o)
      else $error("DLL off in active power-down");

   a_pend_dll_kept:
   assert property (st_r == ssrpd_pkg::ST_PEND && $stable(mr1_r)
                    |-> dll_en_o == dll_on)
      else $error("DLL changed before power-down kind known");

   // Command pins must not move the state while self-refresh holds
   a_sref_cmd_ignore:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_SREF && !cke_rise
                    |=> st_r == ssrpd_pkg::ST_SREF)
      else $error("self-refresh left without clock enable");

   a_sref_exit_go:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_SREF && cke_rise
                    |=> st_r == ssrpd_pkg::ST_NORM)
      else $error("self-refresh exit not taken");

   a_ref_in_sref:
   assert property (sref_ref_o
                    |-> st_r == ssrpd_pkg::ST_SREF)
      else $error("internal refresh outside self-refresh");

   a_ref_one_cycle:
   assert property (sref_ref_o && ce_i
                    |=> !sref_ref_o)
      else $error("internal refresh pulse too long");

   a_dll_rst_pulse:
   assert property (dll_rst_o && ce_i
                    |=> !dll_rst_o)
      else $error("DLL reset pulse too long");

   a_rst_buf_off:
   assert property (st_r == ssrpd_pkg::ST_RST
                    |-> !io_buf_en_o && !dll_rst_o)
      else $error("buffers on in reset state");

   a_norm_bufs_on:
   assert property (st_r == ssrpd_pkg::ST_NORM
                    |-> int_clk_en_o && io_buf_en_o && cmd_rcv_en_o)
      else $error("buffers off in normal state");

   a_pend_exit_norm:
   assert property (ce_i && drst_r && st_r == ssrpd_pkg::ST_PEND && exit_hit
                    |=> st_r == ssrpd_pkg::ST_NORM)
      else $error("early power-down exit not taken");

endmodule

`default_nettype wire

// >>> tb/ssrpd_mc_model.sv
// Memory controller model driving clock enable and command pins
`timescale 1ns/1ps
`default_nettype none

module ssrpd_mc_model (
   input  wire logic                  clk_i,   // Device clock
   output var  ssrpd_pkg::ssrpd_pins_t pins_o   // Clock enable and command pins
);
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;
   localparam logic [3:0] CMD_SRE = 4'h1;

   initial pins_o = 5'h1f;

   // One command per edge, clock enable rides along with it
   task automatic issue(input logic cke, input logic [3:0] cmd);
      @(posedge clk_i);
      pins_o <= {cke, cmd};
   endtask

   // Only called from idle with clock enable high; it then stays low
   task automatic enter_sref();
      issue(1'b0, CMD_SRE);
   endtask

   // Power-down entry with a no-op, never during a burst or register write
   task automatic enter_pd();
      issue(1'b0, CMD_NOP);
   endtask

   // Exit with no-op or deselect; further commands are no-ops only
   task automatic leave(input logic use_des);
      issue(1'b1, use_des ? CMD_DES : CMD_NOP);
   endtask

   // Command pins toggled while clock enable is low; must not be decoded
   task automatic junk();
      issue(1'b0, 4'h0);
   endtask

   // Same code as entry but clock enable stays high: a plain refresh
   task automatic refresh();
      issue(1'b1, CMD_SRE);
   endtask

   // Exit delays counted in whole clocks, no-ops only meanwhile
   task automatic idle(input int n);
      repeat (n) issue(1'b1, CMD_NOP);
   endtask
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the self-refresh and power-down controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic                    core_clk_i;
   logic                    rst_b_i;
   logic                    ce_i;
   logic                    dram_rst_b_i;
   logic                    banks_open_i;
   logic                    op_busy_i;
   logic                    wr_i;
   logic                    rd_i;
   logic [7:0]              addr_i;
   logic [31:0]             wdata_i;
   logic [31:0]             rdata_o;
   ssrpd_pkg::ssrpd_state_t lp_state_o;
   logic                    dll_en_o;
   logic                    dll_rst_o;
   logic                    int_clk_en_o;
   logic                    io_buf_en_o;
   logic                    cmd_rcv_en_o;
   logic                    sref_ref_o;
   ssrpd_pkg::ssrpd_pins_t  pins;
   int                      mismatches;
   int                      checks_done;
   int                      hits;

   ssrpd_mc_model mc (.clk_i(core_clk_i), .pins_o(pins));

   ssrpd_ctrl uut (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cke_i(pins.cke),
      .cs_b_i(pins.cs_b), .ras_b_i(pins.ras_b), .cas_b_i(pins.cas_b), .we_b_i(pins.we_b),
      .dram_rst_b_i(dram_rst_b_i), .banks_open_i(banks_open_i), .op_busy_i(op_busy_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .lp_state_o(lp_state_o), .dll_en_o(dll_en_o), .dll_rst_o(dll_rst_o),
      .int_clk_en_o(int_clk_en_o), .io_buf_en_o(io_buf_en_o),
      .cmd_rcv_en_o(cmd_rcv_en_o), .sref_ref_o(sref_ref_o)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask

   task automatic st_chk(input ssrpd_pkg::ssrpd_state_t s, input logic dll);
      chk({29'h0, lp_state_o}, {29'h0, s});
      chk({31'h0, dll_en_o}, {31'h0, dll});
   endtask

   // Counts one-cycle pulses over a fixed span of edges
   task automatic count(input int n, input logic dll_side);
      hits = 0;
      repeat (n) begin
         @(posedge core_clk_i);
         #1;
         if ((dll_side ? dll_rst_o : sref_ref_o) === 1'b1) hits++;
      end
   endtask

   initial begin
      repeat (3000) @(posedge core_clk_i);
      mismatches++;
      wrap_up();
   end

   initial begin
      {rst_b_i, wr_i, rd_i, banks_open_i, op_busy_i} = '0;
      ce_i = 1'b1;
      {dram_rst_b_i, addr_i, wdata_i, mismatches, checks_done} = {1'b1, 40'h0, 64'h0};
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      settle(5);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      rd_chk(ssrpd_pkg::ADDR_MR1, {16'h0, ssrpd_pkg::MR1_RST});
      rd_chk(ssrpd_pkg::ADDR_MR0, {16'h0, ssrpd_pkg::MR0_RST});
      wr_reg(ssrpd_pkg::ADDR_MR0, 32'hffff_ffff);
      rd_chk(ssrpd_pkg::ADDR_MR0, 32'h0000_ffff);
      wr_reg(8'h0c, 32'hffff_ffff);
      rd_chk(8'h0c, 32'h0);
      wr_reg(ssrpd_pkg::ADDR_STAT, 32'h0);
      rd_chk(ssrpd_pkg::ADDR_STAT, 32'h0000_0078);
      // Clock enable falling with a non-entry command must not enter
      mc.junk();
      settle(5);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      mc.leave(1'b0);
      settle(4);
      mc.enter_sref();
      count(ssrpd_pkg::CKE_CYC + 4, 1'b0);
      chk(hits, 1);
      mc.junk();
      settle(5);
      st_chk(ssrpd_pkg::ST_SREF, 1'b0);
      chk({29'h0, int_clk_en_o, io_buf_en_o, cmd_rcv_en_o}, 32'h0);
      mc.leave(1'b1);
      count(5, 1'b1);
      chk(hits, 1);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      // Idle, one extra refresh, then self-refresh again
      mc.idle(4);
      mc.refresh();
      mc.enter_sref();
      settle(5);
      st_chk(ssrpd_pkg::ST_SREF, 1'b0);
      mc.leave(1'b0);
      settle(5);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      // Slow-exit precharge, fast-exit precharge, then active power-down
      for (int i = 0; i < 3; i++) begin
         wr_reg(ssrpd_pkg::ADDR_MR0, {19'h0, i[0], 12'h0});
         banks_open_i <= (i == 2);
         op_busy_i    <= 1'b1;
         mc.enter_pd();
         settle(6);
         st_chk(ssrpd_pkg::ST_PEND, 1'b1);
         chk({30'h0, io_buf_en_o, cmd_rcv_en_o}, 32'h0);
         @(posedge core_clk_i);
         op_busy_i <= 1'b0;
         settle(2);
         st_chk((i == 2) ? ssrpd_pkg::ST_APD : ssrpd_pkg::ST_PPD, (i != 0));
         mc.leave(i[0]);
         settle(5);
         st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      end
      // Device reset while powered down
      mc.enter_pd();
      settle(8);
      @(posedge core_clk_i);
      dram_rst_b_i <= 1'b0;
      settle(5);
      chk({29'h0, lp_state_o}, {29'h0, ssrpd_pkg::ST_RST});
      mc.leave(1'b0);
      @(posedge core_clk_i);
      dram_rst_b_i <= 1'b1;
      settle(6);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      // Clock enable low freezes the pin syncs and state
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      mc.enter_pd();
      settle(5);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      settle(5);
      st_chk(ssrpd_pkg::ST_APD, 1'b1);
      mc.leave(1'b0);
      settle(5);
      st_chk(ssrpd_pkg::ST_NORM, 1'b1);
      wrap_up();
   end
endmodule

`default_nettype wire
